// ==== rtl/cft_regs.svh ====
// Purpose: timing counts and geometry of the frame readout sequencer
// Assumes: 40 MHz system clock
// Notes:   figures in their own units, cycle counts derived from them
`ifndef CFT_REGS_SVH
`define CFT_REGS_SVH
`define CFT_CLK_NS      25
`define CFT_SYS_KHZ     40000
`define CFT_SER_KHZ     12500
`define CFT_PAR_KHZ     25000
`define CFT_CLR_NS      1000
// least times round up
`define CFT_CLR_CYC     ((`CFT_CLR_NS + `CFT_CLK_NS - 1) / `CFT_CLK_NS)
`define CFT_PIX_CYC     ((`CFT_SYS_KHZ + `CFT_SER_KHZ - 1) / `CFT_SER_KHZ)
`define CFT_PAR_CYC     ((`CFT_SYS_KHZ + `CFT_PAR_KHZ - 1) / `CFT_PAR_KHZ)
`define CFT_XFER_F1     500
`define CFT_XFER_F2     501
`define CFT_DUMMY       4
`define CFT_LINE_ELEM   680
`define CFT_DARK_COLS   22
`define CFT_LINES       500
`define CFT_RESP_CYC    1
`endif

// ==== rtl/cft_pkg.sv ====
// Purpose: types of the frame readout sequencer
// Assumes: nothing
// Notes:   one-hot state codes
package cft_pkg;
   typedef enum logic [4:0] {
      CFT_IDLE  = 5'h01,
      CFT_CLEAR = 5'h02,
      CFT_XFER  = 5'h04,
      CFT_LOAD  = 5'h08,
      CFT_READ  = 5'h10
   } cft_state_t;
endpackage

// ==== rtl/cft_timing_gen.sv ====
// Purpose: timing generator that drives a frame-transfer sensor and
//          collects its digitised video into a stream
// Assumes: sys_clk_i 40 MHz; video samples arrive already digitised
// Notes:
`timescale 1ns/1ps
`include "cft_regs.svh"
module cft_timing_gen #(
   parameter int PIX_W = 12
) (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               srst_i,
   // control
   input  wire logic               frame_start_i,
   input  wire logic               clear_req_i,
   input  wire logic               progressive_i,
   input  wire logic               dual_i,
   output logic                    busy_o,
   output logic                    field_two_o,
   // sensor gates
   output logic                    image_gate_one_o,
   output logic                    image_gate_two_o,
   output logic                    storage_gate_o,
   output logic                    serial_shift_gate_o,
   output logic                    node_reset_gate_o,
   output logic                    overflow_drain_bias_o,
   // correlated double sampling
   output logic                    cds_clamp_o,
   output logic                    sample_hold_o,
   output logic                    line_clamp_o,
   // digitised video from both outputs
   input  wire logic [PIX_W-1:0]   video_output_one_i,
   input  wire logic [PIX_W-1:0]   video_output_two_i,
   // pixel stream
   output logic                    pix_valid_o,
   input  wire logic               pix_ready_i,
   output logic [PIX_W-1:0]        pix_one_o,
   output logic [PIX_W-1:0]        pix_two_o,
   output logic                    pix_dark_o,
   output logic                    pix_last_o
);
   import cft_pkg::*;

   localparam int BW = 2 * PIX_W + 2;

   // refuse widths and rates that the fixed four-phase pixel plan cannot serve
   if (PIX_W < 1 || PIX_W > 16) begin : g_bad_width
      $error("PIX_W out of range");
   end
   if (`CFT_PIX_CYC != 4 || `CFT_PAR_CYC != 2 || `CFT_RESP_CYC != 1) begin : g_bad_rate
      $error("pixel phase plan needs 4-cycle pixel, 2-cycle transfer");
   end

   cft_state_t       st_reg;
   logic [1:0]       ph_reg;
   logic [9:0]       hcnt_reg;
   logic [8:0]       vleft_reg;
   logic [8:0]       xcnt_reg;
   logic [5:0]       clr_reg;
   logic [1:0]       ld_reg;
   logic             dual_reg;
   logic             run;
   logic             real_pix;
   logic             push;
   logic             line_end;
   logic [BW-1:0]    push_data;
   logic [BW-1:0]    head_reg;
   logic [BW-1:0]    tail_reg;
   logic             tail_v_reg;
   logic             pop;
   logic [8:0]       xfer_goal;

   // a pixel only starts when the buffer has room, so no word is lost
   assign run       = (ph_reg != 2'h0) || !tail_v_reg;
   assign real_pix  = hcnt_reg >= 10'(`CFT_DUMMY);
   assign line_end  = (hcnt_reg == 10'(`CFT_DUMMY + `CFT_LINE_ELEM - 1)) && (ph_reg == 2'h3);
   assign push      = (st_reg == CFT_READ) && (ph_reg == 2'h3) && real_pix;
   assign xfer_goal = field_two_o ? 9'(`CFT_XFER_F2) : 9'(`CFT_XFER_F1);
   assign pop       = pix_valid_o && pix_ready_i;
   // single-register modes take register two; one stays zero
   assign push_data = {line_end,
                       hcnt_reg < 10'(`CFT_DUMMY + `CFT_DARK_COLS),
                       video_output_two_i,
                       dual_reg ? video_output_one_i : PIX_W'(0)};

   // sequencer
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_reg    <= CFT_IDLE;
         clr_reg   <= 6'h00;
         xcnt_reg  <= 9'h000;
         vleft_reg <= 9'h000;
         ld_reg    <= 2'h0;
         dual_reg  <= 1'b0;
      end else begin
         case (st_reg)
            CFT_IDLE: begin
               if (clear_req_i) begin
                  clr_reg <= 6'h00;
                  st_reg  <= CFT_CLEAR;
               end else if (frame_start_i) begin
                  dual_reg  <= progressive_i && dual_i;
                  xcnt_reg  <= 9'h000;
                  vleft_reg <= 9'(`CFT_LINES);
                  st_reg    <= CFT_XFER;
               end
            end
            CFT_CLEAR: begin
               clr_reg <= clr_reg + 6'h01;
               if (clr_reg == 6'(`CFT_CLR_CYC - 1)) begin
                  st_reg <= CFT_IDLE;
               end
            end
            CFT_XFER: begin
               if (image_gate_one_o) begin
                  xcnt_reg <= xcnt_reg + 9'h001;
                  if (xcnt_reg + 9'h001 == xfer_goal) begin
                     ld_reg <= 2'h0;
                     st_reg <= CFT_LOAD;
                  end
               end
            end
            CFT_LOAD: begin
               if (storage_gate_o) begin
                  ld_reg <= ld_reg + 2'h1;
                  if (ld_reg + 2'h1 == (dual_reg ? 2'h2 : 2'h1)) begin
                     st_reg <= CFT_READ;
                  end
               end
            end
            CFT_READ: begin
               if (line_end) begin
                  vleft_reg <= vleft_reg - (dual_reg ? 9'h002 : 9'h001);
                  ld_reg    <= 2'h0;
                  if (vleft_reg <= (dual_reg ? 9'h002 : 9'h001)) begin
                     st_reg <= CFT_IDLE;
                  end else begin
                     st_reg <= CFT_LOAD;
                  end
               end
            end
            default: begin
               st_reg <= CFT_IDLE;
            end
         endcase
      end
   end

   // field alternates only for interlaced frames
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         field_two_o <= 1'b0;
      end else if (st_reg == CFT_READ && line_end && vleft_reg <= (dual_reg ? 9'h002 : 9'h001)) begin
         field_two_o <= !progressive_i && !field_two_o;
      end
   end

   // horizontal counter and pixel phase
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || st_reg != CFT_READ) begin
         ph_reg   <= 2'h0;
         hcnt_reg <= 10'h000;
      end else if (run) begin
         ph_reg <= ph_reg + 2'h1;
         if (ph_reg == 2'h3) begin
            hcnt_reg <= line_end ? 10'h000 : hcnt_reg + 10'h001;
         end
      end
   end

   // gate drive; parallel gates toggle every cycle, 20 MHz
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         image_gate_one_o      <= 1'b0;
         image_gate_two_o      <= 1'b0;
         storage_gate_o        <= 1'b0;
         serial_shift_gate_o   <= 1'b0;
         node_reset_gate_o     <= 1'b0;
         overflow_drain_bias_o <= 1'b0;
         cds_clamp_o           <= 1'b0;
         sample_hold_o         <= 1'b0;
         line_clamp_o          <= 1'b0;
         busy_o                <= 1'b0;
      end else begin
         busy_o                <= st_reg != CFT_IDLE;
         overflow_drain_bias_o <= st_reg == CFT_CLEAR;
         case (st_reg)
            CFT_XFER: begin
               image_gate_one_o    <= !image_gate_one_o;
               image_gate_two_o    <= !image_gate_one_o;
               storage_gate_o      <= !image_gate_one_o;
               serial_shift_gate_o <= !image_gate_one_o;
               node_reset_gate_o   <= 1'b0;
               cds_clamp_o         <= 1'b0;
               sample_hold_o       <= 1'b0;
               line_clamp_o        <= 1'b0;
            end
            CFT_LOAD: begin
               image_gate_one_o    <= 1'b0;
               image_gate_two_o    <= 1'b0;
               storage_gate_o      <= !storage_gate_o;
               serial_shift_gate_o <= !storage_gate_o;
               node_reset_gate_o   <= 1'b0;
               cds_clamp_o         <= 1'b0;
               sample_hold_o       <= 1'b0;
               line_clamp_o        <= 1'b0;
            end
            CFT_READ: begin
               image_gate_one_o    <= 1'b0;
               image_gate_two_o    <= 1'b0;
               storage_gate_o      <= 1'b0;
               // one serial clock every four cycles, 10 MHz under nominal
               node_reset_gate_o   <= run && ph_reg == 2'h0;
               serial_shift_gate_o <= ph_reg == 2'h1;
               cds_clamp_o         <= ph_reg == 2'h1;
               sample_hold_o       <= ph_reg == 2'h2;
               line_clamp_o        <= real_pix && hcnt_reg < 10'(`CFT_DUMMY + `CFT_DARK_COLS);
            end
            default: begin
               image_gate_one_o    <= 1'b0;
               image_gate_two_o    <= 1'b0;
               storage_gate_o      <= 1'b0;
               serial_shift_gate_o <= 1'b0;
               node_reset_gate_o   <= 1'b0;
               cds_clamp_o         <= 1'b0;
               sample_hold_o       <= 1'b0;
               line_clamp_o        <= 1'b0;
            end
         endcase
      end
   end

   // two-entry buffer; head drives the outputs straight from flops
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pix_valid_o <= 1'b0;
         tail_v_reg  <= 1'b0;
         head_reg    <= '0;
         tail_reg    <= '0;
      end else if (pop) begin
         if (tail_v_reg) begin
            head_reg   <= tail_reg;
            tail_v_reg <= push;
            tail_reg   <= push_data;
         end else begin
            pix_valid_o <= push;
            head_reg    <= push_data;
         end
      end else if (push) begin
         if (!pix_valid_o) begin
            head_reg    <= push_data;
            pix_valid_o <= 1'b1;
         end else begin
            tail_reg   <= push_data;
            tail_v_reg <= 1'b1;
         end
      end
   end

   assign pix_one_o  = head_reg[PIX_W-1:0];
   assign pix_two_o  = head_reg[2*PIX_W-1:PIX_W];
   assign pix_dark_o = head_reg[2*PIX_W];
   assign pix_last_o = head_reg[2*PIX_W+1];

   // checking helpers
   logic [8:0] xseen_reg;
   logic [5:0] odb_len_reg;
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || st_reg == CFT_IDLE) begin
         xseen_reg <= 9'h000;
      end else if ($rose(image_gate_one_o)) begin
         xseen_reg <= xseen_reg + 9'h001;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || !overflow_drain_bias_o) begin
         odb_len_reg <= 6'h00;
      end else begin
         odb_len_reg <= odb_len_reg + 6'h01;
      end
   end

   sequence s_pix_strobes;
      node_reset_gate_o ##1 (serial_shift_gate_o && cds_clamp_o) ##1 sample_hold_o;
   endsequence

   a_xfer_pulse_count: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $fell(st_reg == CFT_XFER) |->
      xseen_reg == (field_two_o ? 9'(`CFT_XFER_F2) : 9'(`CFT_XFER_F1)))
      else $error("wrong number of parallel transfer pulses");
   a_single_reg_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      push && !dual_reg |-> push_data[PIX_W-1:0] == '0)
      else $error("register one used in single readout");
   a_load_together: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(storage_gate_o) && st_reg == CFT_LOAD |-> serial_shift_gate_o ##1 !storage_gate_o)
      else $error("storage gate without serial gate");
   a_load_count: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(st_reg == CFT_READ) |-> ld_reg == (dual_reg ? 2'h2 : 2'h1))
      else $error("wrong number of lines loaded");
   a_reset_strobes: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(node_reset_gate_o) |-> s_pix_strobes)
      else $error("per-pixel reset, clamp or hold out of order");
   a_serial_rate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      st_reg == CFT_READ && $rose(serial_shift_gate_o) |=> (!serial_shift_gate_o || st_reg != CFT_READ) [*3])
      else $error("serial clock faster than allowed");
   a_sample_after_fall: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      push |-> $fell(serial_shift_gate_o) && sample_hold_o)
      else $error("video taken before serial falling edge");
   a_dummy_first: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      push |-> hcnt_reg >= 10'd4)
      else $error("dummy element pushed as pixel");
   a_clear_length: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $fell(overflow_drain_bias_o) |-> $past(odb_len_reg) >= 6'd39)
      else $error("clear pulse shorter than 1 us");
   a_dark_window: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      push |-> push_data[2*PIX_W] == (hcnt_reg < 10'd26))
      else $error("dark flag on wrong column");
   a_clamp_window: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      st_reg == CFT_READ && ph_reg == 2'h3 && hcnt_reg == 10'd10 |=> line_clamp_o)
      else $error("clamp window missing on dark column");
endmodule // cft_timing_gen

// ==== bench/cft_sensor_model.sv ====
// Purpose: behavioural sensor with digitised outputs for the readout sequencer
// Assumes: video is shown one cycle after the serial gate rises
// Notes:   outside that cycle the outputs carry inverted junk, so a late sample shows
`timescale 1ns/1ps
module cft_sensor_model #(
   parameter int PIX_W = 12
) (
   // clock and reset
   input  wire logic               sys_clk_i,
   input  wire logic               srst_i,
   // gates from the controller
   input  wire logic               image_gate_one_i,
   input  wire logic               storage_gate_i,
   input  wire logic               serial_shift_gate_i,
   // digitised video
   output logic [PIX_W-1:0]        video_output_one_o,
   output logic [PIX_W-1:0]        video_output_two_o
);
   localparam logic [PIX_W-1:0] ONE_MARK = {1'b1, {(PIX_W-1){1'b0}}};
   logic [PIX_W-1:0]  elem_reg;
   logic              in_load_reg;
   logic              both_reg;

   // a second storage pulse in one load means register one holds a line too
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         in_load_reg <= 1'b0;
         both_reg    <= 1'b0;
      end else if (storage_gate_i && !image_gate_one_i) begin
         in_load_reg <= 1'b1;
         both_reg    <= in_load_reg;
      end else if (serial_shift_gate_i && !storage_gate_i) begin
         in_load_reg <= 1'b0;
      end
   end

   // element index counts the dummies too
   always_ff @(posedge sys_clk_i) begin
      if (srst_i || storage_gate_i) begin
         elem_reg <= '0;
      end else if (serial_shift_gate_i) begin
         elem_reg <= elem_reg + 1'b1;
      end
   end

   // both registers shift on the one serial gate; unloaded register gives junk
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         video_output_one_o <= '0;
         video_output_two_o <= '0;
      end else if (serial_shift_gate_i && !storage_gate_i) begin
         video_output_two_o <= elem_reg;
         video_output_one_o <= both_reg ? (elem_reg ^ ONE_MARK) : ~video_output_one_o;
      end else begin
         video_output_one_o <= ~video_output_one_o;
         video_output_two_o <= ~video_output_two_o;
      end
   end
endmodule // cft_sensor_model

// ==== bench/cft_timing_gen_tb.sv ====
// Purpose: self-checking bench for the frame readout sequencer
// Assumes: 40 MHz clock; inputs driven 1 ns after the rising edge
// Notes:   a full frame is over half a million cycles, so each frame test checks
//          transfer count and the first lines, then resets in mid-frame
`timescale 1ns/1ps
module cft_timing_gen_tb;
   localparam int PIX_W = 12;
   logic              sys_clk_i = 1'b0;
   logic              srst_i = 1'b1;
   logic              frame_start_i = 1'b0;
   logic              clear_req_i = 1'b0;
   logic              progressive_i = 1'b0;
   logic              dual_i = 1'b0;
   logic              pix_ready_i = 1'b0;
   logic              busy_o, field_two_o, image_gate_one_o, storage_gate_o, serial_shift_gate_o;
   logic              image_gate_two_o, node_reset_gate_o, cds_clamp_o, sample_hold_o, line_clamp_o;
   logic              overflow_drain_bias_o, pix_valid_o, pix_dark_o, pix_last_o;
   logic [PIX_W-1:0]  video_output_one_i, video_output_two_i, pix_one_o, pix_two_o;
   int                error_cnt = 0;
   int                samples_checked = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   cft_timing_gen #(.PIX_W(PIX_W)) dut (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .frame_start_i(frame_start_i),
      .clear_req_i(clear_req_i), .progressive_i(progressive_i), .dual_i(dual_i),
      .busy_o(busy_o), .field_two_o(field_two_o), .image_gate_one_o(image_gate_one_o),
      .image_gate_two_o(image_gate_two_o), .storage_gate_o(storage_gate_o),
      .serial_shift_gate_o(serial_shift_gate_o), .node_reset_gate_o(node_reset_gate_o),
      .overflow_drain_bias_o(overflow_drain_bias_o), .cds_clamp_o(cds_clamp_o),
      .sample_hold_o(sample_hold_o), .line_clamp_o(line_clamp_o), .video_output_one_i(video_output_one_i),
      .video_output_two_i(video_output_two_i), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i),
      .pix_one_o(pix_one_o), .pix_two_o(pix_two_o), .pix_dark_o(pix_dark_o), .pix_last_o(pix_last_o));

   cft_sensor_model #(.PIX_W(PIX_W)) sensor (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .image_gate_one_i(image_gate_one_o),
      .storage_gate_i(storage_gate_o), .serial_shift_gate_i(serial_shift_gate_o),
      .video_output_one_o(video_output_one_i), .video_output_two_o(video_output_two_i));

   task automatic step();
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic do_reset();
      srst_i = 1'b1;
      repeat (8) step();
      srst_i = 1'b0;
      check(busy_o, 0);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // clear must win over a start raised in the same cycle
   task automatic test_clear();
      int n;
      n = 0;
      clear_req_i = 1'b1;
      frame_start_i = 1'b1;
      step();
      clear_req_i = 1'b0;
      frame_start_i = 1'b0;
      repeat (100) begin
         step();
         if (overflow_drain_bias_o === 1'b1) n++;
      end
      check(n, (1000 + 24) / 25);
      check(busy_o, 0);
      $display("test clear done");
   endtask

   // one frame up to the start of its second line, stalling the stream once
   task automatic test_frame(input logic prog, input logic dual);
      int   pulses, c, n, stall_n, ser_n, rst_n, clamp_n;
      logic prev, prev_ser, prev_rst, both;
      pulses = 0;
      c = 0;
      stall_n = 0;
      ser_n = 0;
      rst_n = 0;
      clamp_n = 0;
      prev = 1'b0;
      prev_ser = 1'b0;
      prev_rst = 1'b0;
      both = prog && dual;
      progressive_i = prog;
      dual_i = dual;
      frame_start_i = 1'b1;
      step();
      frame_start_i = 1'b0;
      // every cycle is watched, the stall included, so strobe counts cover the whole line
      for (n = 0; c < 680 && n < 20000; n++) begin
         if (image_gate_one_o === 1'b1 && !prev) pulses++;
         if (image_gate_one_o === 1'b1) begin
            check({image_gate_two_o, storage_gate_o, serial_shift_gate_o}, 3'h7);
         end
         if (node_reset_gate_o === 1'b1) rst_n++;
         if (line_clamp_o === 1'b1) clamp_n++;
         if (serial_shift_gate_o === 1'b1 && storage_gate_o === 1'b0) begin
            ser_n++;
            check({prev_rst, cds_clamp_o}, 2'h3);
         end
         if (prev_ser) begin
            check({sample_hold_o, serial_shift_gate_o}, 2'h2);
         end
         prev = image_gate_one_o;
         prev_rst = node_reset_gate_o;
         prev_ser = serial_shift_gate_o === 1'b1 && storage_gate_o === 1'b0;
         if (c == 100 && stall_n < 200) begin
            stall_n++;
            pix_ready_i = 1'b0;
         end else begin
            pix_ready_i = 1'b1;
         end
         if (pix_valid_o === 1'b1 && pix_ready_i) begin
            check(pix_two_o, c + 4);
            check(pix_one_o, both ? ((c + 4) ^ 12'h800) : 0);
            check(pix_dark_o, c < 22);
            check(pix_last_o, c == 679);
            c++;
         end
         step();
      end
      check(pulses, 500);
      check(field_two_o, 0);
      check(c, 680);
      check(ser_n, 4 + 680);
      check(rst_n, 4 + 680);
      check(clamp_n, 22 * 4);
      for (n = 0; n < 200 && pix_valid_o !== 1'b1; n++) step();
      check(pix_two_o, 4);
      check(busy_o, 1);
      do_reset();
      $display("test frame prog=%0d dual=%0d done", prog, dual);
   endtask

   initial begin
      #(25 * 60000);
      error_cnt++;
      $display("watchdog expired");
      conclude();
   end

   initial begin
      do_reset();
      test_clear();
      test_frame(1'b1, 1'b0);
      test_frame(1'b1, 1'b1);
      test_frame(1'b0, 1'b1);
      conclude();
   end
endmodule // cft_timing_gen_tb
